/* rtl/dsp_pkg.sv */
// Package: constants and types shared by both ends of the serial control link
package dsp_pkg;
   localparam int FRAME_BITS     = 24;
   localparam int CRC_BITS       = 8;
   localparam int FRAME_CRC_BITS = 32;
   localparam int ADDR_MSB       = 23;
   localparam int ADDR_LSB       = 16;
   localparam int DATA_MSB       = 15;
   localparam int RW_BIT         = 23;
   localparam int NUM_REGS       = 128;
   localparam logic [6:0] ADDR_RSTCFG   = 7'h02;
   localparam logic [6:0] ADDR_CONFIG   = 7'h03;
   localparam logic [6:0] ADDR_NOP      = 7'h00;
   localparam int RSTCFG_PASS_BIT  = 0;
   localparam int CONFIG_CHAIN_DIS_BIT = 0;
   localparam int CONFIG_CRC_EN_BIT    = 1;
   localparam logic [15:0] RESET_VALUE  = 16'h0000;
   localparam logic [7:0]  CRC_POLY     = 8'h07;
   localparam int SCLK_MAX_HZ  = 25000000;
   localparam int CLK_HZ       = 20000000;
   localparam int SCLK_DIV     = 16;
   localparam logic [3:0] SCLK_HALF = 4'h8;
   typedef enum logic [3:0] {
      DSP_IDLE  = 4'b0001,
      DSP_LOW   = 4'b0010,
      DSP_HIGH  = 4'b0100,
      DSP_END   = 4'b1000
   } dsp_host_state_t;
endpackage

/* rtl/dsp_link_if.sv */
// Interface: four-wire serial link between controller and device
`timescale 1ns/10ps
interface dsp_link_if;
   logic sclk;
   logic frame_sel_n;
   logic serial_in;
   logic serial_out;
   logic serial_out_oe;
   modport device (input sclk, input frame_sel_n, input serial_in,
                   output serial_out, output serial_out_oe);
   modport host (output sclk, output frame_sel_n, output serial_in,
                 input serial_out, input serial_out_oe);
endinterface

/* rtl/dsp_device.sv */
// Device end: shift register, frame latch, chain modes and readback
// Contract
// - Frame select high: ignore inputs, output off
// - Host gives exactly 24 falling edges
// - Short frame discarded, registers unchanged
// - Longer frame keeps last 24 bits
// - Latch frame on frame select rise
// - Host lowers frame select per transfer
// - Bits 23:16 address, 15:0 data
// - Serial clock up to 25 MHz, gated/free; the device samples it with the 20 MHz clk and the host drives clk/16
// - Register 0x03 bit disables serial output
// - Register 0x02 bit selects pass-through
// - Normal mode: shifted-out bits on output
// - Frame select fall starts, every edge accepted
// - Host supplies 24 times N clocks
// - All devices latch together, then stop
// - Gated burst or exact free-running window
// - Pass-through routes input straight to output
// - Pass-through takes no data or commands
// - Only hardware reset leaves pass-through
// - Top bit set means read
// - Read data shifted out next frame
// - Frame check: 32-bit frame with CRC
// - Failed CRC frame writes nothing
//
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/10ps
module dsp_device
   import dsp_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Serial link
   dsp_link_if.device       link,
   // User side
   output logic [6:0]       wr_addr,
   output logic [15:0]      wr_data,
   output logic             wr_pulse,
   output logic             pass_through_select,
   output logic             chain_out_disable,
   output logic             frame_check_enable,
   output logic             crc_error
);
   // Pin synchronisers
   logic [1:0]  sclk_sync_ff;
   logic [1:0]  sel_sync_ff;
   logic [1:0]  sin_sync_ff;
   logic        sclk_d_ff;
   logic        sel_d_ff;
   logic [31:0] shift_ff;
   logic [5:0]  cnt_ff;
   logic [31:0] out_ff;
   logic        sout_ff;
   logic        pass_ff;
   logic        dis_ff;
   logic        crc_en_ff;
   logic        crc_err_ff;
   logic [6:0]  wa_ff;
   logic [15:0] wd_ff;
   logic        wp_ff;
   logic [15:0] regs_ff [NUM_REGS];
   logic [6:0]  rd_addr_ff;
   logic        rd_pend_ff;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sclk_sync_ff <= 2'h0;
         sel_sync_ff  <= 2'h3;
         sin_sync_ff  <= 2'h0;
         sclk_d_ff    <= 1'b0;
         sel_d_ff     <= 1'b1;
      end else begin
         sclk_sync_ff <= {sclk_sync_ff[0], link.sclk};
         sel_sync_ff  <= {sel_sync_ff[0], link.frame_sel_n};
         sin_sync_ff  <= {sin_sync_ff[0], link.serial_in};
         sclk_d_ff    <= sclk_sync_ff[1];
         sel_d_ff     <= sel_sync_ff[1];
      end
   end

   // Edges of the synchronised pins
   wire sclk_s   = sclk_sync_ff[1];
   wire sel_s    = sel_sync_ff[1];
   wire sin_s    = sin_sync_ff[1];
   wire active   = !sel_s;
   wire fall     = active && sclk_d_ff && !sclk_s;
   wire rise     = active && !sclk_d_ff && sclk_s;
   wire sel_fall = sel_d_ff && !sel_s;
   wire sel_rise = !sel_d_ff && sel_s;
   // Frame decode
   wire [5:0] need = crc_en_ff ? 6'(FRAME_CRC_BITS) : 6'(FRAME_BITS);
   wire [23:0] frame = crc_en_ff ? shift_ff[31:8] : shift_ff[23:0];
   wire [6:0] f_addr = frame[ADDR_MSB-1:ADDR_LSB];
   wire [15:0] f_data = frame[DATA_MSB:0];
   wire f_read = frame[RW_BIT];

   // CRC remainder over 32 bits, zero when good
   function automatic logic [7:0] crc_rem(input logic [31:0] d);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 31; i >= 0; i--) begin
         c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
      end
      return c;
   endfunction

   // CRC to append to readback frame
   function automatic logic [7:0] crc_gen(input logic [23:0] d);
      return crc_rem({8'h00, d});
   endfunction

   wire crc_ok   = !crc_en_ff || (crc_rem(shift_ff) == 8'h00);
   wire full     = cnt_ff >= need;
   wire accept   = sel_rise && full && !pass_ff;
   wire nop_frame = f_addr == ADDR_NOP;
   wire do_write = accept && crc_ok && !f_read && !nop_frame;
   wire [15:0] rd_val = regs_ff[rd_addr_ff];
   wire [23:0] rd_frame = {1'b0, rd_addr_ff, rd_val};
   // Readback word for the next frame and the bit to launch
   wire [31:0] rd_load = crc_en_ff ? {rd_frame, crc_gen(rd_frame)} : {rd_frame, 8'h00};
   wire [31:0] out_load = rd_pend_ff ? rd_load : 32'h0;
   wire        old_bit  = crc_en_ff ? shift_ff[31] : shift_ff[23];
   wire        nxt_sout = (rd_pend_ff || cnt_ff < need) ? out_ff[31] : old_bit;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         shift_ff <= 32'h0;
         cnt_ff   <= 6'h0;
         out_ff   <= 32'h0;
         sout_ff  <= 1'b0;
      end else begin
         if (sel_fall) begin
            cnt_ff <= 6'h0;
            out_ff <= out_load;
         end
         if (fall && !pass_ff) begin
            shift_ff <= {shift_ff[30:0], sin_s};
            out_ff   <= {out_ff[30:0], 1'b0};
            if (cnt_ff != 6'h3f) begin
               cnt_ff <= cnt_ff + 6'h1;
            end
         end
         if (rise) begin
            sout_ff <= nxt_sout;
         end
      end
   end

   // Configuration, write port and readback state
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pass_ff    <= 1'b0;
         dis_ff     <= 1'b0;
         crc_en_ff  <= 1'b0;
         crc_err_ff <= 1'b0;
         wa_ff      <= 7'h0;
         wd_ff      <= 16'h0;
         wp_ff      <= 1'b0;
         rd_addr_ff <= 7'h0;
         rd_pend_ff <= 1'b0;
      end else begin
         wp_ff <= do_write;
         if (accept && !crc_ok) begin
            crc_err_ff <= 1'b1;
         end else if (!crc_en_ff) begin
            crc_err_ff <= 1'b0;
         end
         if (sel_rise && !pass_ff) begin
            rd_pend_ff <= accept && crc_ok && f_read;
            if (accept && crc_ok && f_read) begin
               rd_addr_ff <= f_addr;
            end
         end
         if (do_write) begin
            wa_ff <= f_addr;
            wd_ff <= f_data;
            if (f_addr == ADDR_RSTCFG && f_data[RSTCFG_PASS_BIT]) begin
               pass_ff <= 1'b1;
            end
            if (f_addr == ADDR_CONFIG) begin
               dis_ff    <= f_data[CONFIG_CHAIN_DIS_BIT];
               crc_en_ff <= f_data[CONFIG_CRC_EN_BIT];
            end
         end
      end
   end

   // Register store, no reset
   always_ff @(posedge clk) begin
      if (do_write) begin
         regs_ff[f_addr] <= f_data;
      end
   end

   // Pass-through routes the raw pin, bypassing the synchroniser delay
   assign link.serial_out    = pass_ff ? link.serial_in : sout_ff;
   // Enable follows the raw select pin so the line frees at once
   assign link.serial_out_oe = !link.frame_sel_n && !dis_ff;

   assign wr_addr             = wa_ff;
   assign wr_data             = wd_ff;
   assign wr_pulse            = wp_ff;
   assign pass_through_select = pass_ff;
   assign chain_out_disable   = dis_ff;
   assign frame_check_enable  = crc_en_ff;
   assign crc_error           = crc_err_ff;
endmodule // dsp_device

/* rtl/dsp_host.sv */
// Host end: serial controller with a small register port
`timescale 1ns/10ps
module dsp_host
   import dsp_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Serial link
   dsp_link_if.host         link,
   // Register port
   input  wire logic [1:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [31:0]      reg_rdata
);
   // 0: tx word, 1: control {len[7:0]}, write starts, 2: rx word, 3: status
   logic [31:0] tx_ff;
   logic [31:0] rx_ff;
   logic [7:0]  len_ff;
   logic [7:0]  bit_ff;
   logic [3:0]  div_ff;
   logic        sclk_ff;
   logic        sel_ff;
   logic        sin_ff;
   logic [1:0]  so_sync_ff;
   logic [31:0] rdata_ff;
   dsp_host_state_t st_ff;

   wire busy   = st_ff != DSP_IDLE;
   wire start  = reg_wr && reg_addr == 2'h1 && !busy && reg_wdata[7:0] != 8'h00;
   wire tick   = div_ff == SCLK_HALF - 4'h1;
   wire [31:0] rd_mux = reg_addr == 2'h0 ? tx_ff :
                        reg_addr == 2'h1 ? {24'h0, len_ff} :
                        reg_addr == 2'h2 ? rx_ff : {31'h0, busy};

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         so_sync_ff <= 2'h0;
         rdata_ff   <= 32'h0;
         tx_ff      <= 32'h0;
         len_ff     <= 8'h0;
      end else begin
         so_sync_ff <= {so_sync_ff[0], link.serial_out};
         rdata_ff   <= reg_rd ? rd_mux : 32'h0;
         if (reg_wr && reg_addr == 2'h0 && !busy) begin
            tx_ff <= reg_wdata;
         end
         if (start) begin
            len_ff <= reg_wdata[7:0];
         end
      end
   end

   // Frame engine: exact count of clocks, then raise frame select
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff   <= DSP_IDLE;
         div_ff  <= 4'h0;
         sclk_ff <= 1'b0;
         sel_ff  <= 1'b1;
         sin_ff  <= 1'b0;
         bit_ff  <= 8'h0;
         rx_ff   <= 32'h0;
      end else begin
         div_ff <= (st_ff == DSP_IDLE || tick) ? 4'h0 : div_ff + 4'h1;
         unique case (st_ff)
            DSP_IDLE: begin
               if (start) begin
                  sel_ff <= 1'b0;
                  bit_ff <= reg_wdata[7:0];
                  sin_ff <= tx_ff[reg_wdata[4:0] - 5'h1];
                  st_ff  <= DSP_LOW;
               end
            end
            DSP_LOW: begin
               if (tick) begin
                  sclk_ff <= 1'b1;
                  // Data changes on the rise so it is settled at the fall
                  sin_ff  <= tx_ff[5'(bit_ff - 8'h1)];
                  st_ff   <= DSP_HIGH;
               end
            end
            DSP_HIGH: begin
               if (tick) begin
                  sclk_ff <= 1'b0;
                  rx_ff   <= {rx_ff[30:0], so_sync_ff[1]};
                  bit_ff  <= bit_ff - 8'h1;
                  if (bit_ff == 8'h1) begin
                     st_ff <= DSP_END;
                  end else begin
                     st_ff  <= DSP_LOW;
                  end
               end
            end
            DSP_END: begin
               if (tick) begin
                  sel_ff <= 1'b1;
                  st_ff  <= DSP_IDLE;
               end
            end
         endcase
      end
   end

   assign link.sclk        = sclk_ff;
   assign link.frame_sel_n = sel_ff;
   assign link.serial_in   = sin_ff;
   assign reg_rdata        = rdata_ff;
endmodule // dsp_host

/* verif/dsp_assertions.sv */
// Checker: timing relations on the four link wires
`timescale 1ns/10ps
module dsp_assertions (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Link wires
   input wire logic sclk,
   input wire logic frame_sel_n,
   input wire logic serial_in,
   input wire logic serial_out,
   input wire logic serial_out_oe
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   sequence s_high;
      sclk [*8] ##1 !sclk;
   endsequence
   sequence s_low;
      !sclk [*8];
   endsequence
   property p_out_off;
      frame_sel_n |-> !serial_out_oe;
   endproperty
   a_out_off: assert property (p_out_off) else $error("serial out driven while idle");
   property p_clk_still;
      frame_sel_n |-> !sclk;
   endproperty
   a_clk_still: assert property (p_clk_still) else $error("clock runs outside frame");
   property p_high_time;
      $rose(sclk) |-> s_high;
   endproperty
   a_high_time: assert property (p_high_time) else $error("clock high time wrong");
   property p_low_time;
      $fell(sclk) |-> s_low;
   endproperty
   a_low_time: assert property (p_low_time) else $error("clock low time wrong");
   property p_data_hold;
      sclk && $past(sclk) |-> $stable(serial_in);
   endproperty
   a_data_hold: assert property (p_data_hold) else $error("data moved while clock high");
   property p_end_quiet;
      $rose(frame_sel_n) |-> !sclk && !$past(sclk) && !$past(sclk, 2) && !$past(sclk, 3);
   endproperty
   a_end_quiet: assert property (p_end_quiet) else $error("frame closed too soon");
   property p_start_idle;
      $fell(frame_sel_n) |-> !sclk;
   endproperty
   a_start_idle: assert property (p_start_idle) else $error("frame opened with clock high");
   property p_gap;
      $rose(frame_sel_n) |=> frame_sel_n;
   endproperty
   a_gap: assert property (p_gap) else $error("no gap between frames");
endmodule // dsp_assertions

/* verif/dsp_bench.sv */
// Testbench: host and device joined over the link, driven through the host port
`timescale 1ns/10ps
module dsp_bench;
   import dsp_pkg::*;
   logic        clk;
   logic        rst_n;
   logic [1:0]  reg_addr;
   logic [31:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [31:0] reg_rdata;
   logic [6:0]  wr_addr;
   logic [15:0] wr_data;
   logic        wr_pulse, pass_sel, out_dis, crc_en, crc_error, oe_seen;
   logic [31:0] n_pulse, p0, v;
   int          n_errors, n_checks, cyc;
   dsp_link_if lnk ();
   dsp_device dsp_device_inst (.clk(clk), .rst_n(rst_n), .link(lnk.device),
      .wr_addr(wr_addr), .wr_data(wr_data), .wr_pulse(wr_pulse),
      .pass_through_select(pass_sel), .chain_out_disable(out_dis),
      .frame_check_enable(crc_en), .crc_error(crc_error));
   dsp_host dsp_host_inst (.clk(clk), .rst_n(rst_n), .link(lnk.host), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   dsp_assertions dsp_assertions_inst (.clk(clk), .rst_n(rst_n), .sclk(lnk.sclk),
      .frame_sel_n(lnk.frame_sel_n), .serial_in(lnk.serial_in),
      .serial_out(lnk.serial_out), .serial_out_oe(lnk.serial_out_oe));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      if (wr_pulse === 1'b1) n_pulse++;
      if (lnk.serial_out_oe === 1'b1) oe_seen = 1'b1;
      cyc++;
      if (cyc == 30000) begin
         n_errors++;
         print_verdict();
      end
   end
   function automatic logic [7:0] crc8(input logic [23:0] f);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 23; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ f[i]) ? 8'h07 : 8'h00);
      return c;
   endfunction
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task wr(input logic [1:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [1:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      d = reg_rdata;
   endtask
   task send(input logic [31:0] w, input logic [5:0] n);
      logic [31:0] s;
      p0 = n_pulse;
      wr(2'h0, w);
      wr(2'h1, {26'h0, n});
      for (int i = 0; i < 500; i++) begin
         rd(2'h3, s);
         if (s[0] === 1'b0) break;
      end
      chk("idle", 32'(s[0]), 32'h0);
      repeat (10) @(posedge clk);
   endtask
   task do_reset;
      rst_n <= 1'b0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
   endtask
   task print_verdict;
      if (n_errors == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      rst_n = 1'b0;
      {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
      {n_pulse, n_errors, n_checks, cyc, oe_seen} = '0;
      do_reset();
      send(32'h0005a5c3, 6'd24);
      chk("pulse", n_pulse - p0, 32'd1);
      chk("addr", 32'(wr_addr), 32'h05);
      chk("data", 32'(wr_data), 32'ha5c3);
      rd(2'h1, v);
      chk("len", v, 32'd24);
      send(32'h00061111, 6'd23);
      chk("short", n_pulse - p0, 32'd0);
      chk("data", 32'(wr_data), 32'ha5c3);
      send(32'hff061234, 6'd32);
      chk("addr", 32'(wr_addr), 32'h06);
      chk("data", 32'(wr_data), 32'h1234);
      send(32'h00850000, 6'd24);
      chk("read", n_pulse - p0, 32'd0);
      send(32'h00000000, 6'd24);
      chk("nop", n_pulse - p0, 32'd0);
      rd(2'h2, v);
      chk("readback", v & 32'hffffff, 32'h05a5c3);
      send(32'h00030001, 6'd24);
      chk("outdis", 32'(out_dis), 32'h1);
      oe_seen = 1'b0;
      send(32'h00000000, 6'd24);
      chk("oe off", 32'(oe_seen), 32'h0);
      send(32'h00030000, 6'd24);
      oe_seen = 1'b0;
      send(32'h00000000, 6'd24);
      chk("oe on", 32'(oe_seen), 32'h1);
      send(32'h00030002, 6'd24);
      chk("crcen", 32'(crc_en), 32'h1);
      send({24'h071234, crc8(24'h071234)}, 6'd32);
      chk("crc ok", n_pulse - p0, 32'd1);
      chk("crcerr", 32'(crc_error), 32'h0);
      send({24'h07abcd, crc8(24'h07abcd) ^ 8'h01}, 6'd32);
      chk("crc bad", n_pulse - p0, 32'd0);
      chk("data", 32'(wr_data), 32'h1234);
      chk("crcerr", 32'(crc_error), 32'h1);
      send({24'h870000, crc8(24'h870000)}, 6'd32);
      send({24'h000000, crc8(24'h000000)}, 6'd32);
      chk("nop crc", n_pulse - p0, 32'd0);
      rd(2'h2, v);
      chk("crc rdbk", v, {24'h071234, crc8(24'h071234)});
      do_reset();
      send(32'h00020001, 6'd24);
      chk("pass", 32'(pass_sel), 32'h1);
      send(32'h0005beef, 6'd24);
      chk("pass wr", n_pulse - p0, 32'd0);
      rd(2'h2, v);
      chk("pass out", v & 32'hffffff, 32'h05beef);
      do_reset();
      chk("pass rst", 32'(pass_sel), 32'h0);
      send(32'h0005beef, 6'd24);
      chk("wr again", n_pulse - p0, 32'd1);
      chk("data", 32'(wr_data), 32'hbeef);
      print_verdict();
   end
endmodule // dsp_bench
